// >>> rtl/ifgc_pkg.sv
// shared constants of the frequency gate counter
package ifgc_pkg;
  localparam int          CLK_KHZ      = 100000;  // system clock rate in kHz
  localparam int          OSC_KHZ      = 4500;    // oscillator rate in kHz
  localparam int          ACC_W        = 17;
  localparam logic [16:0] ACC_MOD      = 17'(CLK_KHZ);
  localparam logic [16:0] ACC_STEP     = 17'(OSC_KHZ);
  localparam int          DIV_W        = 13;
  localparam logic [12:0] DIV_1K       = 13'(OSC_KHZ / 1);    // oscillator ticks per 1 kHz period
  localparam logic [12:0] DIV_100K     = 13'(OSC_KHZ / 100);
  localparam logic [12:0] DIV_900K     = 13'(OSC_KHZ / 900);
  localparam int          GATE_1_MS    = 1;
  localparam int          GATE_4_MS    = 4;
  localparam int          GATE_8_MS    = 8;
  localparam int          CNT_W        = 16;
  localparam int          CGP_W        = 6;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam int          BIT_CLEAR    = 0;       // counter_clear_bit position
  localparam int          BIT_START    = 1;       // count_start_bit position
  localparam int          BIT_GATE     = 0;       // gate_open_flag position
  localparam logic [3:0]  CTRL_RDVAL   = 4'h0;    // value shown for an undefined read
  // function select codes
  localparam logic [1:0]  MODE_CGP     = 2'h0;
  localparam logic [1:0]  MODE_FM      = 2'h1;
  localparam logic [1:0]  MODE_AM      = 2'h2;
  // gate time / reference select codes
  localparam logic [1:0]  SEL_1        = 2'h0;
  localparam logic [1:0]  SEL_4        = 2'h1;
  localparam logic [1:0]  SEL_8        = 2'h2;
  localparam logic [1:0]  SEL_OPEN     = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_OPEN = 3'b100
  } ifgc_state_t;
endpackage : ifgc_pkg

// >>> rtl/ifgc_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module ifgc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_q, s2_q, s3_q;

  // stage chain; the first stage feeds only the second; it runs through reset so it is full when reset ends
  always_ff @(posedge clk) begin
    s1_q <= pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // a change is accepted once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= s3_q;  // follow the pin during reset so no false edge follows it; reset needs four clocks
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= (s2_q == s3_q) && s3_q && !level;
      fall <= (s2_q == s3_q) && !s3_q && level;
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule : ifgc_sync
`default_nettype wire

// >>> rtl/ifgc_top.sv
// frequency gate counter: if counter and external gate counter with 16-bit count
`timescale 1ns/10ps
`default_nettype none
module ifgc_top
  import ifgc_pkg::*;
#(
  parameter int CLK_KHZ_P = CLK_KHZ  // system clock rate in kHz; must exceed the oscillator rate
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             fm_if_input,
  input  wire logic             am_if_input,
  input  wire logic             external_gate_counter,
  input  wire logic [1:0]       mode_sel,
  input  wire logic [1:0]       gate_sel,
  input  wire logic             ctrl_wr,
  input  wire logic [3:0]       ctrl_wdata,
  input  wire logic             ctrl_rd,
  input  wire logic             cgp_wr,
  input  wire logic [CGP_W-1:0] cgp_wdata,
  input  wire logic             done_clr,
  output logic [3:0]            ctrl_rdata,
  output logic [CNT_W-1:0]      count_data,
  output logic [3:0]            gate_judge_status,
  output logic                  count_done_request
);
  localparam logic [ACC_W-1:0] ACC_MOD_P = ACC_W'(CLK_KHZ_P);  // accumulator modulus from the clock rate

  logic              fm_fall, am_lvl, am_fall, eg_lvl, eg_rise;
  logic [ACC_W-1:0]  acc_q;
  logic              osc_tick_q;
  logic [DIV_W-1:0]  ms_div_q, ref_div_q;
  logic              ms_tick_q, ref_tick_q;
  logic              fm_half_q, fm_half_fall_q;
  logic [3:0]        ms_cnt_q;
  ifgc_state_t       state_q;
  logic              gate_flag_q;
  logic              is_if, is_ext, start_cmd, clear_cmd, open_now, close_now;
  logic              edge_in, sel_lvl, extra;
  logic [CNT_W-1:0]  cnt_d;

  function automatic logic [3:0] gate_ms(input logic [1:0] sel);
    unique case (sel)
      SEL_4:   gate_ms = 4'(GATE_4_MS);
      SEL_8:   gate_ms = 4'(GATE_8_MS);
      default: gate_ms = 4'(GATE_1_MS);
    endcase
  endfunction : gate_ms

  ifgc_sync u_fm (.clk(clk), .rst(rst), .pin(fm_if_input), .level(), .rise(), .fall(fm_fall));
  ifgc_sync u_am (.clk(clk), .rst(rst), .pin(am_if_input), .level(am_lvl), .rise(), .fall(am_fall));
  ifgc_sync u_eg (.clk(clk), .rst(rst), .pin(external_gate_counter), .level(eg_lvl), .rise(eg_rise),
                  .fall());

  // 4.5 MHz oscillator tick made from the system clock by phase accumulation
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q      <= '0;
      osc_tick_q <= 1'b0;
    end else if (acc_q + ACC_STEP >= ACC_MOD_P) begin
      acc_q      <= ACC_W'(acc_q + ACC_STEP - ACC_MOD_P);
      osc_tick_q <= 1'b1;
    end else begin
      acc_q      <= ACC_W'(acc_q + ACC_STEP);
      osc_tick_q <= 1'b0;
    end
  end

  // 1 kHz gate base divided from the oscillator
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_div_q  <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= 1'b0;
      if (osc_tick_q) begin
        if (ms_div_q == DIV_1K - 13'h0001) begin
          ms_div_q  <= '0;
          ms_tick_q <= 1'b1;
        end else begin
          ms_div_q <= ms_div_q + 13'h0001;
        end
      end
    end
  end

  // selectable reference for external gate mode; open code gives no ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_div_q  <= '0;
      ref_tick_q <= 1'b0;
    end else begin
      ref_tick_q <= 1'b0;
      if (osc_tick_q && gate_sel != SEL_OPEN) begin
        if (ref_div_q + 13'h0001 >= (gate_sel == SEL_1 ? DIV_1K : gate_sel == SEL_4 ? DIV_100K : DIV_900K)) begin
          ref_div_q  <= '0;
          ref_tick_q <= 1'b1;
        end else begin
          ref_div_q <= ref_div_q + 13'h0001;
        end
      end
    end
  end

  // fm input halved by a toggle; its falling edge is every second fm fall
  always_ff @(posedge clk) begin
    if (rst) begin
      fm_half_q      <= 1'b0;
      fm_half_fall_q <= 1'b0;
    end else begin
      fm_half_fall_q <= fm_fall && fm_half_q;
      if (fm_fall) begin
        fm_half_q <= !fm_half_q;
      end
    end
  end

  // command decode and selected source
  always_comb begin
    is_if     = (mode_sel == MODE_FM) || (mode_sel == MODE_AM);
    is_ext    = mode_sel[1] && (mode_sel != MODE_AM);
    start_cmd = ctrl_wr && ctrl_wdata[BIT_START];
    clear_cmd = ctrl_wr && ctrl_wdata[BIT_CLEAR];
    open_now  = (state_q == ST_WAIT) && (is_if ? ms_tick_q : eg_rise);
    close_now = (state_q == ST_OPEN) &&
                (is_if ? (ms_tick_q && ms_cnt_q + 4'h1 >= gate_ms(gate_sel)) : eg_rise);
    unique case (mode_sel)
      MODE_FM: begin
        edge_in = fm_half_fall_q;
        sel_lvl = fm_half_q;
      end
      MODE_AM: begin
        edge_in = am_fall;
        sel_lvl = am_lvl;
      end
      MODE_CGP: begin
        edge_in = 1'b0;
        sel_lvl = 1'b1;
      end
      default: begin
        edge_in = ref_tick_q;
        sel_lvl = eg_lvl;
      end
    endcase
    extra = open_now && !sel_lvl;
  end

  // gate sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      ms_cnt_q <= '0;
    end else begin
      if (ms_tick_q && state_q == ST_OPEN) begin
        ms_cnt_q <= ms_cnt_q + 4'h1;
      end
      unique case (state_q)
        ST_IDLE: if (start_cmd && mode_sel != MODE_CGP) begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: if (open_now) begin
          state_q  <= ST_OPEN;
          ms_cnt_q <= '0;
        end
        ST_OPEN: if (close_now) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // gate flag: set by start, cleared only by an if mode gate close
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_flag_q <= 1'b0;
    end else if (start_cmd) begin
      gate_flag_q <= 1'b1;
    end else if (close_now && is_if) begin
      gate_flag_q <= 1'b0;
    end
  end

  // done request: set on gate close wins over software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      count_done_request <= 1'b0;
    end else if (close_now) begin
      count_done_request <= 1'b1;
    end else if (done_clr) begin
      count_done_request <= 1'b0;
    end
  end

  // 16-bit counter with clear, counting, and clock port overwrite of the top bits
  always_comb begin
    cnt_d = count_data;
    if (state_q == ST_OPEN || (is_if && gate_sel == SEL_OPEN)) begin
      cnt_d = CNT_W'(cnt_d + {15'h0000, edge_in});
    end
    cnt_d = CNT_W'(cnt_d + {15'h0000, extra});
    if (cgp_wr) begin
      cnt_d[CNT_W-1 -: CGP_W] = cgp_wdata;
    end
    if (clear_cmd) begin
      cnt_d = CNT_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_data <= CNT_ZERO;
    end else begin
      count_data <= cnt_d;
    end
  end

  // status and undefined control read-back
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_judge_status <= 4'h0;
      ctrl_rdata        <= CTRL_RDVAL;
    end else begin
      gate_judge_status            <= 4'h0;
      gate_judge_status[BIT_GATE]  <= gate_flag_q;
      ctrl_rdata                   <= ctrl_rd ? CTRL_RDVAL : ctrl_rdata;
    end
  end

  // checks
  clear_zero_a: assert property (@(posedge clk) disable iff (rst)
    clear_cmd |=> count_data == CNT_ZERO) else $error("clear did not zero counter");
  start_flag_a: assert property (@(posedge clk) disable iff (rst)
    start_cmd |=> ##1 gate_judge_status[BIT_GATE]) else $error("start did not set gate flag");
  if_close_a: assert property (@(posedge clk) disable iff (rst)
    close_now && is_if && !start_cmd |=> !gate_flag_q && count_done_request) else $error("if close wrong");
  ext_hold_a: assert property (@(posedge clk) disable iff (rst)
    close_now && is_ext |=> gate_flag_q == $past(gate_flag_q) || $past(start_cmd)) else $error("ext flag moved");
  wrap_zero_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_OPEN || (is_if && gate_sel == SEL_OPEN)) && count_data == CNT_MAX && edge_in
    && !cgp_wr && !clear_cmd |=> count_data == CNT_ZERO) else $error("counter did not wrap");
  gate_len_a: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_OPEN && is_if && ms_tick_q && ms_cnt_q + 4'h1 == gate_ms(gate_sel)
    |=> state_q == ST_IDLE) else $error("if gate length wrong");
  ext_open_a: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_WAIT && is_ext && eg_rise |=> state_q == ST_OPEN) else $error("ext gate did not open");
  hold_cnt_a: assert property (@(posedge clk) disable iff (rst)
    state_q != ST_OPEN && !open_now && !(is_if && gate_sel == SEL_OPEN) && !ctrl_wr && !cgp_wr
    |=> $stable(count_data)) else $error("count changed while closed");
  cgp_over_a: assert property (@(posedge clk) disable iff (rst)
    cgp_wr && !clear_cmd |=> count_data[CNT_W-1 -: CGP_W] == $past(cgp_wdata)) else $error("port write lost");

  if_run_c: cover property (@(posedge clk) disable iff (rst) close_now && is_if);
  ext_run_c: cover property (@(posedge clk) disable iff (rst) close_now && is_ext);
  wrap_c: cover property (@(posedge clk) disable iff (rst) count_data == CNT_MAX ##1 count_data == CNT_ZERO);
endmodule : ifgc_top
`default_nettype wire

// >>> test/ifgc_src.sv
// pin source model: if signals and external gate pulse
`timescale 1ns/10ps
`default_nettype none
module ifgc_src (
  input  wire logic clk,
  output logic      fm_pin,
  output logic      am_pin,
  output logic      gate_pin
);
  // pins rest high between bursts
  initial begin
    fm_pin   = 1'b1;
    am_pin   = 1'b1;
    gate_pin = 1'b1;
  end
  // n periods of 2*h clocks, falling edge first
  task automatic burst(input bit fm, input int n, input int h);
    for (int i = 0; i < n; i++) begin
      repeat (h) @(negedge clk);
      if (fm) fm_pin = 1'b0; else am_pin = 1'b0;
      repeat (h) @(negedge clk);
      if (fm) fm_pin = 1'b1; else am_pin = 1'b1;
    end
  endtask : burst
  // two rising edges w clocks apart open and close the gate
  task automatic gate(input int w);
    repeat (8) @(negedge clk);
    gate_pin = 1'b0;
    repeat (8) @(negedge clk);
    gate_pin = 1'b1;
    repeat (w / 2) @(negedge clk);
    gate_pin = 1'b0;
    repeat (w / 2) @(negedge clk);
    gate_pin = 1'b1;
  endtask : gate
endmodule : ifgc_src
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench of the frequency gate counter
`timescale 1ns/10ps
`default_nettype none
module testbench import ifgc_pkg::*;;
  logic             clk, rst, fm, am, gate, ctrl_wr, ctrl_rd, cgp_wr, done_clr, done, ok;
  logic [1:0]       mode_sel, gate_sel;
  logic [3:0]       ctrl_wdata, ctrl_rdata, status;
  logic [CGP_W-1:0] cgp_wdata;
  logic [15:0]      count, exp, held;
  int               error_cnt, comparisons;
  localparam int    TB_CLK_KHZ = 10000;  // timebase runs ten times fast: a 1 ms gate lasts 10000 clocks

  ifgc_src src (.clk(clk), .fm_pin(fm), .am_pin(am), .gate_pin(gate));
  ifgc_top #(.CLK_KHZ_P(TB_CLK_KHZ)) DUT (.clk(clk), .rst(rst), .fm_if_input(fm), .am_if_input(am),
    .external_gate_counter(gate),
    .mode_sel(mode_sel), .gate_sel(gate_sel), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rd(ctrl_rd),
    .cgp_wr(cgp_wr), .cgp_wdata(cgp_wdata), .done_clr(done_clr), .ctrl_rdata(ctrl_rdata),
    .count_data(count), .gate_judge_status(status), .count_done_request(done));

  // clock of 10 ns
  always #5 clk = ~clk;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  // one-cycle strobe: 0 control write, 1 port write, 2 control read, 3 done clear; ends one edge later
  task automatic strobe(input int which, input logic [5:0] d);
    @(negedge clk);
    ctrl_wdata = d[3:0];
    cgp_wdata  = d;
    ctrl_wr    = (which == 0);
    cgp_wr     = (which == 1);
    ctrl_rd    = (which == 2);
    done_clr   = (which == 3);
    @(negedge clk);
    {ctrl_wr, cgp_wr, ctrl_rd, done_clr} = 4'h0;
    @(negedge clk);
  endtask : strobe

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // watchdog against a hung run; the tests need about 50000 clocks
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {mode_sel, gate_sel} = {MODE_CGP, SEL_1};
    {ctrl_wr, cgp_wr, ctrl_rd, done_clr} = 4'h0;
    ctrl_wdata = 4'h0;
    cgp_wdata = 6'h00;
    error_cnt = 0;
    comparisons = 0;
    settle(5);
    rst = 1'b0;
    check("reset count", count, CNT_ZERO);
    check("reset status", {12'h000, status}, 16'h0000);
    check("reset done", {15'h0000, done}, 16'h0000);
    strobe(2, 6'h00);
    check("control read", {12'h000, ctrl_rdata}, {12'h000, CTRL_RDVAL});
    // open gate: am counted whole, fm halved, fast and slow pins
    for (int k = 0; k < 2; k++) begin
      mode_sel = k ? MODE_FM : MODE_AM;
      gate_sel = SEL_OPEN;
      settle(50);
      strobe(0, 6'h01);
      check("cleared count", count, CNT_ZERO);
      src.burst(bit'(k), 40, k ? 3 : 6);
      settle(10);
      check("if count", count, 16'h0028 >> k);
    end
    // port data lands in the top six bits, then counting wraps past all ones
    mode_sel = MODE_CGP;
    strobe(0, 6'h01);
    strobe(1, 6'h3F);
    check("port bits", count, 16'hFC00);
    mode_sel = MODE_AM;
    settle(50);
    src.burst(1'b0, 1030, 2);
    settle(10);
    check("wrapped count", count, 16'h0006);
    // 1 ms if gate counts 1000 am falls, one more if the pin is low at opening
    gate_sel = SEL_1;
    strobe(3, 6'h00);
    strobe(0, 6'h03);
    check("if flag on start", {12'h000, status}, 16'h0001);
    fork
      src.burst(1'b0, 2100, 5);
      begin
        for (int t = 0; t < 21000 && done !== 1'b1; t++) settle(1);
        settle(2);
        check("if done", {15'h0000, done}, 16'h0001);
        check("if flag drop", {12'h000, status}, 16'h0000);
        ok = (count >= 16'h03E8) && (count <= 16'h03E9);
        check("if gate count", {15'h0000, ok}, 16'h0001);
      end
    join
    // external gate counts the 100 kHz and 900 kHz references over 10000 clocks
    mode_sel = 2'h3;
    for (int s = 1; s < 3; s++) begin
      gate_sel = s[1:0];
      strobe(3, 6'h00);
      strobe(0, 6'h03);
      settle(1);
      check("flag on start", {12'h000, status}, 16'h0001);
      fork
        src.gate(10000);
        begin
          settle(5000);
          check("done while open", {15'h0000, done}, 16'h0000);
        end
      join
      for (int t = 0; t < 20 && done !== 1'b1; t++) settle(1);
      check("done at close", {15'h0000, done}, 16'h0001);
      check("flag stays", {12'h000, status}, 16'h0001);
      exp = (s == 1) ? 16'h0064 : 16'h0384;
      ok = (count >= exp - 16'h0001) && (count <= exp + 16'h0001);
      check("reference count", {15'h0000, ok}, 16'h0001);
      held = count;
      settle(2000);
      check("held count", count, held);
      strobe(3, 6'h00);
      check("done cleared", {15'h0000, done}, 16'h0000);
    end
    complete_run();
  end
endmodule : testbench
`default_nettype wire
